// *** src/brc_defs.svh ***
// Contract
// RQ1 - enabling code keeps brownout detection on except in sleep or idle mode
// RQ2 - brownout reset only after low supply lasts beyond the filter time
// RQ3 - qualified brownout reset sets the brownout flag
// RQ4 - five valid threshold codes each pick one trip level
// RQ5 - code 11110000 disables brownout reset entirely
// RQ6 - any other code resets after a delay and restores power-on value
// RQ7 - undefined threshold code reset sets the threshold code fault flag
// RQ8 - genuine brownout reset keeps the threshold select contents
// RQ9 - threshold select powers on as 01100110
// RQ10 - hardware only sets cause flags; only software writes clear them
// RQ11 - upper four bits of reset cause flags read as zero
// RQ12 - writing 55h to flash command register one resets the whole device
// RQ13 - watchdog expiry in normal mode acts as brownout reset, sets expired flag
// RQ14 - watchdog expiry in sleep or idle clears pc and sp, sets both flags
// RQ15 - power-on clears expired and power-down flags; pin or brownout keep them
// RQ16 - power-on reset zeroes pc, disables interrupts, clears timers, ports input
// RQ17 - invalid reset pin select code sets the reset select fault flag
// RQ18 - filter time and corrupt code delay are parameterised cycle counts
`ifndef BRC_DEFS_SVH
`define BRC_DEFS_SVH
// ****************************************
// register offsets
// ****************************************
`define BRC_ADDR_THRESH 4'h0
`define BRC_ADDR_CAUSE 4'h1
`define BRC_ADDR_FLASHCMD 4'h2
`define BRC_ADDR_PINSEL 4'h3
`define BRC_ADDR_STATUS 4'h4
`define BRC_ADDR_IRQSTAT 4'h5
`define BRC_ADDR_IRQCLR 4'h6
`define BRC_ADDR_IRQEN 4'h7
// ****************************************
// codes and reset values
// ****************************************
`define BRC_CODE_1V7 8'h66
`define BRC_CODE_1V9 8'h55
`define BRC_CODE_2V55 8'h33
`define BRC_CODE_3V15 8'h99
`define BRC_CODE_3V8 8'haa
`define BRC_CODE_OFF 8'hf0
`define BRC_THRESH_POR 8'h66
`define BRC_PINSEL_IO 8'h55
`define BRC_PINSEL_PIN 8'haa
`define BRC_PINSEL_POR 8'h55
`define BRC_FLASH_RESET 8'h55
// ****************************************
// field positions
// ****************************************
`define BRC_CAUSE_WDF 0
`define BRC_CAUSE_TCF 1
`define BRC_CAUSE_BOF 2
`define BRC_CAUSE_RSF 3
`define BRC_STAT_EXPIRED 0
`define BRC_STAT_PWRDN 1
// ****************************************
// timing
// ****************************************
`define BRC_FILTER_NS 1000
`define BRC_SRESET_NS 2000
`define BRC_CLK_MHZ 200
`define BRC_FILTER_CYC ((`BRC_FILTER_NS * `BRC_CLK_MHZ + 999) / 1000)
`define BRC_SRESET_CYC ((`BRC_SRESET_NS * `BRC_CLK_MHZ + 999) / 1000)
`define BRC_RESET_PULSE 4
`endif

// *** src/brc_pkg.sv ***
package brc_pkg;
  // which reset is in progress
  typedef enum logic [2:0] {
    BRC_RST_NONE,
    BRC_RST_BROWNOUT,
    BRC_RST_CODE,
    BRC_RST_PINSEL,
    BRC_RST_FLASH,
    BRC_RST_WDOG
  } brc_cause_t;
  // register bus request
  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } brc_bus_t;
  // event strobes into the irq status
  typedef struct packed {
    logic wdogLow;
    logic wdog;
    logic flash;
    logic pinsel;
    logic code;
    logic brownout;
  } brc_evt_t;
endpackage

// *** src/brc_reset_logic.sv ***
`include "brc_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module brc_reset_logic import brc_pkg::*; #(
  parameter int FILTER_CYC = `BRC_FILTER_CYC,
  parameter int SRESET_CYC = `BRC_SRESET_CYC,
  parameter int PULSE_CYC = `BRC_RESET_PULSE
) (
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic powerOnReset,
  input wire logic externalResetPin,
  input wire logic supplyLow,
  input wire logic lowPowerMode,
  input wire logic watchdogExpired,
  input wire brc_bus_t busReq,
  output logic [7:0] rdData,
  output logic deviceReset,
  output logic pcSpClear,
  output logic [2:0] tripLevel,
  output logic detectEnable,
  output logic irq
);
  // ****************************************
  // elaboration checks
  // ****************************************
  // the delay counters are 16 bits wide, the pulse counter 8
  if (FILTER_CYC < 1 || FILTER_CYC > 65535) begin : gBadFilter
    $error("brc_reset_logic: filter count out of range");
  end
  if (SRESET_CYC < 1 || SRESET_CYC > 65535) begin : gBadDelay
    $error("brc_reset_logic: code delay count out of range");
  end
  if (PULSE_CYC < 1 || PULSE_CYC > 255) begin : gBadPulse
    $error("brc_reset_logic: pulse count out of range");
  end

  // ****************************************
  // state
  // ****************************************
  // software visible select registers
  logic [7:0] threshSel;
  logic [7:0] pinSel;

  // sticky flags, set by hardware only
  logic [3:0] causeFlags;
  logic toFlag;
  logic pdFlag;

  // interrupt status and mask
  logic [5:0] irqStat;
  logic [5:0] irqEn;

  // filter and delay counters
  logic [15:0] filterCnt;
  logic [15:0] codeCnt;
  logic [15:0] pinCnt;

  // reset sequencing
  logic [7:0] pulseCnt;
  brc_cause_t active;
  logic resetting;

  // ****************************************
  // functions
  // ****************************************
  // valid threshold code check, also maps a trip level
  function automatic logic [3:0] thresh_decode(input logic [7:0] code);
    if (code == `BRC_CODE_1V7) begin
      thresh_decode = 4'h8;
    end else if (code == `BRC_CODE_1V9) begin
      thresh_decode = 4'h9;
    end else if (code == `BRC_CODE_2V55) begin
      thresh_decode = 4'ha;
    end else if (code == `BRC_CODE_3V15) begin
      thresh_decode = 4'hb;
    end else if (code == `BRC_CODE_3V8) begin
      thresh_decode = 4'hc;
    end else begin
      thresh_decode = 4'h0;
    end
  endfunction

  // one strobe aimed at one register
  function automatic logic addr_hit(input logic strobe, input logic [3:0] addr,
                                    input logic [3:0] target);
    addr_hit = strobe && (addr == target);
  endfunction

  // climbs while its condition holds and parks at the limit, so it cannot wrap
  function automatic logic [15:0] sat_count(input logic [15:0] cnt, input int limit);
    if (cnt != 16'(limit)) begin
      sat_count = cnt + 16'h0001;
    end else begin
      sat_count = cnt;
    end
  endfunction

  // sticky flag: a hardware set beats a software clear in the same cycle
  function automatic logic flag_next(input logic set, input logic wr, input logic keep,
                                     input logic cur);
    if (set) begin
      flag_next = 1'b1;
    end else if (wr) begin
      flag_next = keep & cur;
    end else begin
      flag_next = cur;
    end
  endfunction

  // ****************************************
  // decode
  // ****************************************
  wire logic [3:0] threshInfo = thresh_decode(threshSel); // RQ4
  wire logic codeValid = threshInfo[3];
  wire logic codeOff = (threshSel == `BRC_CODE_OFF); // RQ5
  wire logic codeBad = !codeValid && !codeOff; // RQ6
  wire logic pinBad = (pinSel != `BRC_PINSEL_IO) && (pinSel != `BRC_PINSEL_PIN);
  wire logic next_detectEnable = codeValid && !lowPowerMode; // RQ1
  wire logic lowSeen = next_detectEnable && supplyLow;
  wire logic wrHit = busReq.wr && !resetting;
  wire logic wrThresh = addr_hit(wrHit, busReq.addr, `BRC_ADDR_THRESH);
  wire logic wrCause = addr_hit(wrHit, busReq.addr, `BRC_ADDR_CAUSE);
  wire logic wrFlash = addr_hit(wrHit, busReq.addr, `BRC_ADDR_FLASHCMD);
  wire logic wrPin = addr_hit(wrHit, busReq.addr, `BRC_ADDR_PINSEL);
  wire logic wrIrqClr = addr_hit(wrHit, busReq.addr, `BRC_ADDR_IRQCLR);
  wire logic wrIrqEn = addr_hit(wrHit, busReq.addr, `BRC_ADDR_IRQEN);

  // ****************************************
  // reset triggers
  // ****************************************
  // triggers; longer than the filter time means count reaching it while low
  wire logic trigBrown = lowSeen && (filterCnt == 16'(FILTER_CYC)); // RQ2
  wire logic trigCode = codeBad && (codeCnt == 16'(SRESET_CYC)); // RQ6
  wire logic trigPin = pinBad && (pinCnt == 16'(SRESET_CYC)); // RQ17
  wire logic trigFlash = wrFlash && (busReq.wdata == `BRC_FLASH_RESET); // RQ12
  wire logic trigWdog = watchdogExpired && !lowPowerMode; // RQ13
  wire logic trigWdogLow = watchdogExpired && lowPowerMode; // RQ14
  wire logic trigExt = externalResetPin && (pinSel == `BRC_PINSEL_PIN);
  wire logic anyTrig = !resetting && (trigBrown || trigCode || trigPin || trigFlash ||
                       trigWdog || trigExt);

  // ****************************************
  // reset cause
  // ****************************************
  // one cause per reset, brownout first
  wire brc_cause_t next_cause = trigBrown ? BRC_RST_BROWNOUT :
                                trigCode ? BRC_RST_CODE :
                                trigPin ? BRC_RST_PINSEL :
                                trigFlash ? BRC_RST_FLASH :
                                trigWdog ? BRC_RST_WDOG : BRC_RST_NONE;
  wire brc_evt_t evt = '{
    wdogLow: trigWdogLow && !resetting,
    wdog: trigWdog && anyTrig,
    flash: trigFlash && anyTrig,
    pinsel: trigPin && anyTrig,
    code: trigCode && anyTrig,
    brownout: trigBrown && anyTrig};
  // full resets restore the select registers; brownout keeps them
  wire logic restoreRegs = anyTrig && (trigCode || trigPin || trigFlash || trigWdog ||
                           trigExt) && !trigBrown; // RQ8

  // ****************************************
  // read mux
  // ****************************************
  logic [7:0] next_rdData;
  // write-only and unmapped addresses read as zero
  always_comb begin
    if (!busReq.rd) begin
      next_rdData = 8'h00;
    end else if (busReq.addr == `BRC_ADDR_THRESH) begin
      next_rdData = threshSel;
    end else if (busReq.addr == `BRC_ADDR_CAUSE) begin
      next_rdData = {4'h0, causeFlags}; // RQ11
    end else if (busReq.addr == `BRC_ADDR_PINSEL) begin
      next_rdData = pinSel;
    end else if (busReq.addr == `BRC_ADDR_STATUS) begin
      next_rdData = {6'h00, pdFlag, toFlag};
    end else if (busReq.addr == `BRC_ADDR_IRQSTAT) begin
      next_rdData = {2'h0, irqStat};
    end else if (busReq.addr == `BRC_ADDR_IRQEN) begin
      next_rdData = {2'h0, irqEn};
    end else begin
      next_rdData = 8'h00;
    end
  end

  // ****************************************
  // filter and delay counters
  // ****************************************
  // a dip that ends before the count lands restarts the filter
  always_ff @(posedge clk_sys) begin
    if (srst || powerOnReset || !lowSeen || resetting) begin
      filterCnt <= 16'h0000;
    end else begin
      filterCnt <= sat_count(filterCnt, FILTER_CYC); // RQ2 RQ18
    end
  end

  // corrupt code delays
  always_ff @(posedge clk_sys) begin
    if (srst || powerOnReset || !codeBad || resetting) begin
      codeCnt <= 16'h0000;
    end else begin
      codeCnt <= sat_count(codeCnt, SRESET_CYC); // RQ18
    end
  end

  // pin select corruption uses the same delay
  always_ff @(posedge clk_sys) begin
    if (srst || powerOnReset || !pinBad || resetting) begin
      pinCnt <= 16'h0000;
    end else begin
      pinCnt <= sat_count(pinCnt, SRESET_CYC);
    end
  end

  // ****************************************
  // reset pulse generator
  // ****************************************
  always_ff @(posedge clk_sys) begin
    if (srst || powerOnReset) begin
      resetting <= 1'b1; // RQ16
      pulseCnt <= 8'(PULSE_CYC);
      active <= BRC_RST_NONE;
    end else if (anyTrig) begin
      resetting <= 1'b1;
      pulseCnt <= 8'(PULSE_CYC);
      active <= next_cause;
    end else if (pulseCnt != 8'h00) begin
      pulseCnt <= pulseCnt - 8'h01;
    end else begin
      resetting <= 1'b0;
      active <= BRC_RST_NONE;
    end
  end

  // ****************************************
  // select registers
  // ****************************************
  // a brownout keeps the threshold code, corruption restores it
  always_ff @(posedge clk_sys) begin
    if (srst || powerOnReset || restoreRegs) begin
      threshSel <= `BRC_THRESH_POR; // RQ6 RQ9
    end else if (wrThresh) begin
      threshSel <= busReq.wdata;
    end
  end

  // pin select, restored by every full reset but a brownout
  always_ff @(posedge clk_sys) begin
    if (srst || powerOnReset || restoreRegs) begin
      pinSel <= `BRC_PINSEL_POR;
    end else if (wrPin) begin
      pinSel <= busReq.wdata;
    end
  end

  // ****************************************
  // reset cause flags
  // ****************************************
  // set beats a same-cycle software clear
  always_ff @(posedge clk_sys) begin
    if (srst || powerOnReset) begin
      causeFlags <= 4'h0;
    end else begin
      causeFlags[`BRC_CAUSE_WDF] <= flag_next(1'b0, wrCause, busReq.wdata[`BRC_CAUSE_WDF],
                                              causeFlags[`BRC_CAUSE_WDF]);
      causeFlags[`BRC_CAUSE_TCF] <= flag_next(evt.code, wrCause, busReq.wdata[`BRC_CAUSE_TCF],
                                              causeFlags[`BRC_CAUSE_TCF]); // RQ7 RQ10
      causeFlags[`BRC_CAUSE_BOF] <= flag_next(evt.brownout, wrCause,
        busReq.wdata[`BRC_CAUSE_BOF], causeFlags[`BRC_CAUSE_BOF]); // RQ3 RQ10
      causeFlags[`BRC_CAUSE_RSF] <= flag_next(evt.pinsel, wrCause,
        busReq.wdata[`BRC_CAUSE_RSF], causeFlags[`BRC_CAUSE_RSF]); // RQ17 RQ10
    end
  end

  // ****************************************
  // expired and power-down flags
  // ****************************************
  // pin, brownout and flash resets leave them alone
  always_ff @(posedge clk_sys) begin
    if (srst || powerOnReset) begin
      toFlag <= 1'b0; // RQ15
    end else if (evt.wdogLow || evt.wdog) begin
      toFlag <= 1'b1; // RQ13 RQ14
    end
  end

  // power-down flag, set only by a low-power watchdog expiry
  always_ff @(posedge clk_sys) begin
    if (srst || powerOnReset) begin
      pdFlag <= 1'b0; // RQ15
    end else if (evt.wdogLow) begin
      pdFlag <= 1'b1; // RQ14
    end
  end

  // ****************************************
  // interrupt block
  // ****************************************
  // status bits: events set, ones written to the clear register drop them
  always_ff @(posedge clk_sys) begin
    if (srst || powerOnReset) begin
      irqStat <= 6'h00;
    end else begin
      irqStat <= evt | (irqStat & ~(wrIrqClr ? busReq.wdata[5:0] : 6'h00));
    end
  end

  // enable mask; only srst or power-on clears it, so warm resets keep interrupts armed
  always_ff @(posedge clk_sys) begin
    if (srst || powerOnReset) begin
      irqEn <= 6'h00;
    end else if (wrIrqEn) begin
      irqEn <= busReq.wdata[5:0];
    end
  end

  // ****************************************
  // registered outputs
  // ****************************************
  // pulse still running after the trigger edge
  wire logic pulseLive = resetting && (pulseCnt != 8'h00);

  // read data stand for the one cycle after the read strobe
  always_ff @(posedge clk_sys) begin
    if (srst || powerOnReset) begin
      rdData <= 8'h00;
    end else begin
      rdData <= next_rdData;
    end
  end

  // full reset out, the trigger edge plus the pulse count
  always_ff @(posedge clk_sys) begin
    if (srst || powerOnReset) begin
      deviceReset <= 1'b1; // RQ16
    end else begin
      deviceReset <= anyTrig || pulseLive;
    end
  end

  // pc and stack clear; alone for one cycle on a low-power watchdog
  always_ff @(posedge clk_sys) begin
    if (srst || powerOnReset) begin
      pcSpClear <= 1'b1;
    end else begin
      pcSpClear <= anyTrig || evt.wdogLow || pulseLive; // RQ14
    end
  end

  // trip level index for the comparator, zero when off or corrupt
  always_ff @(posedge clk_sys) begin
    if (srst || powerOnReset) begin
      tripLevel <= 3'h0;
    end else begin
      tripLevel <= threshInfo[2:0];
    end
  end

  // detection gate; one cycle of lag is harmless against the filter
  always_ff @(posedge clk_sys) begin
    if (srst || powerOnReset) begin
      detectEnable <= 1'b0;
    end else begin
      detectEnable <= next_detectEnable; // RQ1
    end
  end

  // level interrupt, one cycle behind the status bits
  always_ff @(posedge clk_sys) begin
    if (srst || powerOnReset) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irqStat & irqEn);
    end
  end
endmodule
`default_nettype wire

// *** tb/brc_reset_logic_props.sv ***
`timescale 1ns/1ps
`default_nettype none
// ****
// port checker
// ****
module brc_reset_logic_props import brc_pkg::*; #(
  parameter int FILTER_CYC = 3
) (
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic powerOnReset,
  input wire logic supplyLow,
  input wire logic lowPowerMode,
  input wire logic watchdogExpired,
  input wire brc_bus_t busReq,
  input wire logic [7:0] rdData,
  input wire logic deviceReset,
  input wire logic pcSpClear,
  input wire logic detectEnable,
  input wire logic irq
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (srst || powerOnReset);
  logic [3:0] lowCnt;
  // cycles of qualified low supply; a stuck filter shows as a runaway count
  always_ff @(posedge clk_sys) begin
    if (srst || !supplyLow || !detectEnable || deviceReset) lowCnt <= 4'h0;
    else if (lowCnt != 4'hf) lowCnt <= lowCnt + 4'h1;
  end
  a_sleep_detect_off: assert property (lowPowerMode |=> !detectEnable)
    else $error("detection active in low power");
  a_brown_bound: assert property (int'(lowCnt) <= FILTER_CYC + 3)
    else $error("long low supply gave no reset");
  a_flash_reset: assert property (busReq.wr && busReq.addr == 4'h2 &&
    busReq.wdata == 8'h55 && !deviceReset |=> deviceReset) else $error("flash reset missing");
  a_upper_zero: assert property (busReq.rd && busReq.addr == 4'h1 |=> rdData[7:4] == 4'h0)
    else $error("cause upper bits set");
  a_wdog_low: assert property (watchdogExpired && lowPowerMode && !deviceReset
    |=> pcSpClear && !deviceReset) else $error("low power watchdog wrong");
  a_wdog_run: assert property (watchdogExpired && !lowPowerMode && !deviceReset
    |-> ##[1:2] deviceReset) else $error("watchdog reset missing");
  a_pulse_len: assert property ($rose(deviceReset) |-> deviceReset[*3])
    else $error("reset pulse too short");
  a_pcsp_with: assert property (deviceReset |-> pcSpClear)
    else $error("pc clear absent in reset");
  c_reset: cover property ($rose(deviceReset));
  c_low_wdog: cover property (pcSpClear && !deviceReset);
  c_irq: cover property ($rose(irq));
endmodule
`default_nettype wire

// *** tb/testbench.sv ***
`timescale 1ns/1ps
`default_nettype none
// ****
// bench top
// ****
module testbench import brc_pkg::*;;
  logic clk_sys, srst, powerOnReset, externalResetPin, supplyLow, lowPowerMode;
  logic watchdogExpired, deviceReset, pcSpClear, detectEnable, irq;
  brc_bus_t busReq;
  logic [7:0] rdData, code, cause, stat;
  logic [2:0] tripLevel;
  logic [31:0] seed;
  logic [7:0] codes [5] = '{8'h66, 8'h55, 8'h33, 8'h99, 8'haa};
  int errors, checked, cyc;
  brc_reset_logic #(.FILTER_CYC(3), .SRESET_CYC(5), .PULSE_CYC(2)) i_brc_reset_logic (
    .clk_sys(clk_sys), .srst(srst), .powerOnReset(powerOnReset),
    .externalResetPin(externalResetPin), .supplyLow(supplyLow), .lowPowerMode(lowPowerMode),
    .watchdogExpired(watchdogExpired), .busReq(busReq), .rdData(rdData),
    .deviceReset(deviceReset), .pcSpClear(pcSpClear), .tripLevel(tripLevel),
    .detectEnable(detectEnable), .irq(irq));
  // 5 ns clock
  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end
  function automatic logic [7:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_sys) busReq <= {a, d, 2'b10};
    @(posedge clk_sys) busReq <= '0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] exp);
    @(posedge clk_sys) busReq <= {a, 8'h00, 2'b01};
    @(posedge clk_sys) busReq <= '0;
    #1 chk(rdData, exp);
  endtask
  // watch a fixed span; drop the stimulus once the reset shows so it cannot retrigger
  task automatic waitRst(input logic exp);
    logic seen;
    seen = 1'b0;
    repeat (40) begin
      @(posedge clk_sys);
      if (deviceReset) begin
        seen = 1'b1;
        supplyLow <= 1'b0;
        externalResetPin <= 1'b0;
      end
    end
    chk(8'(seen), 8'(exp));
  endtask
  task automatic wdog();
    @(posedge clk_sys) watchdogExpired <= 1'b1;
    @(posedge clk_sys) watchdogExpired <= 1'b0;
  endtask
  task automatic chkIrq(input logic exp);
    repeat (2) @(posedge clk_sys);
    #1 chk(8'(irq), 8'(exp));
  endtask
  task automatic end_of_test();
    $display("checked %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // hang guard, far above the whole sequence
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 20000) begin
      errors++;
      end_of_test();
    end
  end
  // ****
  // scenarios
  // ****
  initial begin
    {srst, powerOnReset, externalResetPin, supplyLow, lowPowerMode, watchdogExpired} = 6'h20;
    busReq = '0;
    seed = 32'h5f16;
    cause = 8'h00;
    stat = 8'h00;
    repeat (20) @(posedge clk_sys);
    srst <= 1'b0;
    repeat (6) @(posedge clk_sys);
    rd(4'h0, 8'h66);
    rd(4'h1, cause);
    rd(4'h4, stat);
    rd(4'h9, 8'h00);
    foreach (codes[i]) begin
      wr(4'h0, codes[i]);
      rd(4'h0, codes[i]);
      chk(8'(tripLevel), 8'(i));
    end
    // a low episode exactly as long as the filter must pass unnoticed
    @(posedge clk_sys) supplyLow <= 1'b1;
    repeat (3) @(posedge clk_sys);
    supplyLow <= 1'b0;
    waitRst(1'b0);
    wr(4'h0, 8'hf0);
    supplyLow <= 1'b1;
    waitRst(1'b0);
    wr(4'h0, 8'h33);
    lowPowerMode <= 1'b1;
    waitRst(1'b0);
    lowPowerMode <= 1'b0;
    waitRst(1'b1);
    cause |= 8'h04;
    rd(4'h1, cause);
    rd(4'h0, 8'h33);
    do code = xs(); while (code inside {8'h66, 8'h55, 8'h33, 8'h99, 8'haa, 8'hf0});
    wr(4'h0, code);
    waitRst(1'b1);
    cause |= 8'h02;
    rd(4'h1, cause);
    rd(4'h0, 8'h66);
    do code = xs(); while (code inside {8'h55, 8'haa});
    wr(4'h3, code);
    waitRst(1'b1);
    cause |= 8'h08;
    rd(4'h1, cause);
    wr(4'h1, 8'hf3);
    cause &= 8'hf3;
    rd(4'h1, cause);
    wr(4'h2, 8'h54);
    waitRst(1'b0);
    wr(4'h2, 8'h55);
    waitRst(1'b1);
    rd(4'h1, cause);
    wdog();
    waitRst(1'b1);
    stat = 8'h01;
    rd(4'h4, stat);
    wr(4'h3, 8'haa);
    externalResetPin <= 1'b1;
    waitRst(1'b1);
    rd(4'h4, stat);
    wr(4'h6, 8'hff);
    wr(4'h7, 8'h20);
    lowPowerMode <= 1'b1;
    wdog();
    #1 chk(8'(pcSpClear), 8'h01);
    waitRst(1'b0);
    lowPowerMode <= 1'b0;
    stat = 8'h03;
    rd(4'h4, stat);
    rd(4'h5, 8'h20);
    chkIrq(1'b1);
    wr(4'h7, 8'h00);
    chkIrq(1'b0);
    wr(4'h7, 8'h20);
    chkIrq(1'b1);
    wr(4'h6, 8'h20);
    chkIrq(1'b0);
    @(posedge clk_sys) powerOnReset <= 1'b1;
    repeat (3) @(posedge clk_sys);
    powerOnReset <= 1'b0;
    repeat (6) @(posedge clk_sys);
    rd(4'h4, 8'h00);
    rd(4'h1, 8'h00);
    end_of_test();
  end
endmodule
bind brc_reset_logic brc_reset_logic_props #(.FILTER_CYC(FILTER_CYC)) i_props (
  .clk_sys, .srst, .powerOnReset, .supplyLow, .lowPowerMode, .watchdogExpired, .busReq,
  .rdData, .deviceReset, .pcSpClear, .detectEnable, .irq);
`default_nettype wire
